// ==== core/tpp_defs.svh ====
// Register offsets, field layout and reset values of the two-pin port
`ifndef TPP_DEFS_SVH
`define TPP_DEFS_SVH
`define TPP_LATCH_IDX     4'hb
`define TPP_DIR_IDX       4'hc
`define TPP_LATCH_ADDR    12'h02c
`define TPP_DIR_ADDR      12'h030
`define TPP_PIN_COUNT     2
`define TPP_DIR_RESET     2'h0
`define TPP_HTRANS_NONSEQ 2'h2
`define TPP_HTRANS_SEQ    2'h3
`endif

// ==== core/tpp_pkg.sv ====
// Types shared by the two-pin port
package tpp_pkg;
    typedef logic [1:0] tpp_pins_t;
    typedef enum logic [1:0] {
        TPP_SEL_NONE  = 2'h0,
        TPP_SEL_LATCH = 2'h1,
        TPP_SEL_DIR   = 2'h3
    } tpp_sel_e;
endpackage : tpp_pkg

// ==== core/tpp_port.sv ====
// Two-pin general-purpose port with AHB-Lite register slave
//
// Functional notes
// - A direction bit of 1 drives its pin, a 0 releases it as a high-impedance input.
// - Reset clears both direction bits so every pin starts as an input.
// - Software can read and write the direction bits and reads back what it stored.
// - A data read of a bit whose direction is 1 returns the latch bit.
// - A data read of a bit whose direction is 0 returns the sampled pin level.
// - The latch accepts writes at all times, whatever the direction bits hold.
// - Writing the latch of an input pin changes only the latch, never what is sensed.
// - The port has exactly two pins, each with its own latch bit and direction bit.
// - Reset leaves the latch bits untouched, so they hold no defined value until written.
//
// The implementer's own choice: the AHB-Lite slave port.
`timescale 1ns/10ps
`include "tpp_defs.svh"

module tpp_port #(
    parameter int PINS = `TPP_PIN_COUNT
) (
    input  wire logic              clk,
    input  wire logic              nrst,
    input  wire logic              hsel,
    input  wire logic [11:0]       haddr,
    input  wire logic [1:0]        htrans,
    input  wire logic              hwrite,
    input  wire logic [2:0]        hsize,
    input  wire logic [31:0]       hwdata,
    input  wire logic              hready,
    output logic      [31:0]       hrdata,
    output logic                   hreadyout,
    output logic                   hresp,
    input  wire logic [PINS-1:0]   pinIn,
    output logic      [PINS-1:0]   pinOut,
    output logic      [PINS-1:0]   pinOen_n
);

    // Latch has no reset: plain flop
    logic [PINS-1:0]  pinOutputLatch;
    logic [PINS-1:0]  pinDirectionBits;
    logic [PINS-1:0]  syncA;
    logic [PINS-1:0]  syncB;
    logic [PINS-1:0]  syncC;
    logic [PINS-1:0]  pinLevel;
    logic             wrPend;
    tpp_pkg::tpp_sel_e wrSel;
    logic             latchSeen;

    function automatic tpp_pkg::tpp_sel_e decode(input logic [11:0] a);
        if (a == `TPP_LATCH_ADDR) begin
            return tpp_pkg::TPP_SEL_LATCH;
        end else if (a == `TPP_DIR_ADDR) begin
            return tpp_pkg::TPP_SEL_DIR;
        end
        return tpp_pkg::TPP_SEL_NONE;
    endfunction : decode

    wire              addrPhase = hsel && hready && htrans[1];
    wire tpp_pkg::tpp_sel_e curSel = decode(haddr);
    // Only word accesses are decoded; narrower ones are ignored
    wire              wordAcc   = (hsize == 3'h2);
    wire              doRead    = addrPhase && !hwrite && wordAcc;
    wire              wrLatch   = wrPend && (wrSel == tpp_pkg::TPP_SEL_LATCH);
    wire              wrDir     = wrPend && (wrSel == tpp_pkg::TPP_SEL_DIR);
    // Input pins read the pin, output pins read the latch
    wire [PINS-1:0]   dataView  = (pinDirectionBits & pinOutputLatch)
                                | (~pinDirectionBits & pinLevel);
    // Forward a write still in its data phase, so a pipelined read is not stale
    wire [PINS-1:0]   dirNow    = wrDir ? hwdata[PINS-1:0] : pinDirectionBits;
    wire [PINS-1:0]   latNow    = wrLatch ? hwdata[PINS-1:0] : pinOutputLatch;
    wire [PINS-1:0]   viewNow   = (dirNow & latNow) | (~dirNow & pinLevel);
    wire [31:0]       rdMux     = (curSel == tpp_pkg::TPP_SEL_LATCH) ? 32'(viewNow) :
                                  (curSel == tpp_pkg::TPP_SEL_DIR) ? 32'(dirNow) :
                                  32'h0;

    assign hreadyout = 1'b1;
    assign hresp     = 1'b0;
    assign pinOut    = pinOutputLatch;
    assign pinOen_n  = ~pinDirectionBits;

    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            wrPend <= 1'b0;
            wrSel  <= tpp_pkg::TPP_SEL_NONE;
            hrdata <= 32'h0;
        end else begin
            wrPend <= addrPhase && hwrite && wordAcc;
            wrSel  <= curSel;
            hrdata <= doRead ? rdMux : 32'h0;
        end
    end

    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            pinDirectionBits <= `TPP_DIR_RESET;
        end else if (wrDir) begin
            pinDirectionBits <= hwdata[PINS-1:0];
        end
    end

    // Written whatever the direction; does not touch the sampled pins
    always_ff @(posedge clk) begin
        if (wrLatch) begin
            pinOutputLatch <= hwdata[PINS-1:0];
        end
    end

    // Three-stage sampler; level updates when stages two and three agree
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            syncA    <= '0;
            syncB    <= '0;
            syncC    <= '0;
            pinLevel <= '0;
        end else begin
            syncA    <= pinIn;
            syncB    <= syncA;
            syncC    <= syncB;
            pinLevel <= (syncB & syncC) | (pinLevel & (syncB ^ syncC));
        end
    end

    // Latch has no reset, so its checks wait for the first write
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            latchSeen <= 1'b0;
        end else if (wrLatch) begin
            latchSeen <= 1'b1;
        end
    end

    a_dir_reset: assert property (
        @(posedge clk)
        $rose(nrst) |-> pinDirectionBits == '0)
        else $error("direction not cleared by reset");

    a_oen_follow: assert property (
        @(posedge clk) disable iff (!nrst)
        pinOen_n == ~pinDirectionBits)
        else $error("output enable does not follow direction");

    a_out_latch: assert property (
        @(posedge clk) disable iff (!nrst)
        latchSeen |-> pinOut == pinOutputLatch)
        else $error("pin drive does not follow latch");

    a_dir_write: assert property (
        @(posedge clk) disable iff (!nrst)
        wrDir |=> pinDirectionBits == $past(hwdata[PINS-1:0]))
        else $error("direction write lost");

    a_dir_hold: assert property (
        @(posedge clk) disable iff (!nrst)
        !wrDir |=> pinDirectionBits == $past(pinDirectionBits))
        else $error("direction changed without write");

    a_latch_write: assert property (
        @(posedge clk) disable iff (!nrst)
        wrLatch |=> pinOut == $past(hwdata[PINS-1:0]))
        else $error("latch write lost");

    a_read_view: assert property (
        @(posedge clk) disable iff (!nrst)
        doRead && curSel == tpp_pkg::TPP_SEL_LATCH
        |=> hrdata[PINS-1:0] == $past(viewNow))
        else $error("data read wrong");

    a_read_pin: assert property (
        @(posedge clk) disable iff (!nrst)
        doRead && curSel == tpp_pkg::TPP_SEL_LATCH && dirNow == '0
        |=> hrdata[PINS-1:0] == $past(pinLevel))
        else $error("input pin read wrong");

    a_level_hold: assert property (
        @(posedge clk) disable iff (!nrst)
        syncB != syncC |=> pinLevel == $past(pinLevel))
        else $error("pin level moved on disagreeing samples");

    a_upper_zero: assert property (
        @(posedge clk) disable iff (!nrst)
        hrdata[31:PINS] == '0)
        else $error("upper bits not zero");

    a_rdata_idle: assert property (
        @(posedge clk) disable iff (!nrst)
        !doRead |=> hrdata == 32'h0)
        else $error("read data outside a read");

    a_bus_okay: assert property (
        @(posedge clk) disable iff (!nrst)
        hreadyout && !hresp)
        else $error("bus answer not ready or not okay");

    a_latch_keep: assert property (
        @(posedge clk) disable iff (!nrst)
        latchSeen && !wrLatch |=> pinOut == $past(pinOut))
        else $error("latch changed without write");

    c_dir_write: cover property (
        @(posedge clk) disable iff (!nrst)
        wrDir);

    c_latch_wr_in: cover property (
        @(posedge clk) disable iff (!nrst)
        wrLatch && pinDirectionBits == '0);

    c_read_mix: cover property (
        @(posedge clk) disable iff (!nrst)
        doRead && pinDirectionBits == 2'h1);

    c_pin_settle: cover property (
        @(posedge clk) disable iff (!nrst)
        syncB != syncC ##1 syncB == syncC);

endmodule : tpp_port

// ==== tb/tpp_board.sv ====
// Board model that resolves the two port pins
`timescale 1ns/10ps
module tpp_board (
    input  wire logic [1:0] boardDrive,
    input  wire logic [1:0] pinOut,
    input  wire logic [1:0] pinOen_n,
    output logic      [1:0] pinIn
);
    // Enabled buffer wins; a released pin shows the board level
    assign pinIn = (pinOut & ~pinOen_n) | (boardDrive & pinOen_n);
endmodule : tpp_board

// ==== tb/two_pin_port_direction_control_tb.sv ====
// Self-checking bench of the two-pin port
`timescale 1ns/10ps
module two_pin_port_direction_control_tb;
    logic        clk = 0, nrst = 0, hsel = 0, hwrite = 0, hreadyout, hresp;
    logic [11:0] haddr = '0;
    logic [1:0]  htrans = '0, bd = '0, pinIn, pinOut, pinOen_n;
    logic [2:0]  hsize = 3'h2;
    logic [31:0] hwdata = '0, hrdata, r;
    int          errTotal = 0, nCompared = 0, lat, dir;
    always #20 clk = ~clk;
    tpp_port i_tpp_port (.clk(clk), .nrst(nrst), .hsel(hsel), .haddr(haddr), .htrans(htrans),
        .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout), .hrdata(hrdata),
        .hreadyout(hreadyout), .hresp(hresp), .pinIn(pinIn), .pinOut(pinOut),
        .pinOen_n(pinOen_n));
    tpp_board i_tpp_board (.boardDrive(bd), .pinOut(pinOut), .pinOen_n(pinOen_n), .pinIn(pinIn));
    task chk(input logic [31:0] got, input logic [31:0] exp);
        nCompared++;
        if (got !== exp) begin
            errTotal++;
            $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : chk
    // One single transfer at the current hsize; read data lands in r
    task bus(input logic w, input logic [11:0] a, input logic [31:0] d);
        @(posedge clk);
        hsel   <= 1'b1;
        haddr  <= a;
        hwrite <= w;
        htrans <= 2'h2;
        do @(posedge clk); while (hreadyout !== 1'b1);
        hsel   <= 1'b0;
        htrans <= 2'h0;
        hwdata <= d;
        do @(posedge clk); while (hreadyout !== 1'b1);
        r = hrdata;
    endtask : bus
    task results();
        if (errTotal == 0 && nCompared > 0)
            $display("SIMULATION PASSED");
        else
            $display("SIMULATION FAILED");
        $finish;
    endtask : results
    initial begin
        void'($urandom(32'h3065adb4));
        repeat (3) @(posedge clk);
        nrst <= 1'b1;
        bus(0, 12'h030, 0);
        chk(r, 0);
        chk(32'(pinOen_n), 32'h3);
        for (int i = 0; i < 8; i++) begin
            lat = $urandom;
            dir = $urandom;
            bd  <= 2'($urandom);
            bus(1, 12'h02c, lat);
            // Latch first, so a new output never glitches
            bus(1, 12'h030, dir);
            dir = dir & 3;
            lat = lat & 3;
            // Pin samples pass a filter before a read sees them
            repeat (6) @(posedge clk);
            bus(0, 12'h030, 0);
            chk(r, dir);
            bus(0, 12'h02c, 0);
            chk(r, (lat & dir) | (bd & ~dir & 3));
            chk(32'(pinOen_n), ~dir & 3);
            chk(32'(pinOut), lat);
        end
        // Byte write must be dropped, only word accesses count
        hsize <= 3'h0;
        bus(1, 12'h030, ~dir);
        hsize <= 3'h2;
        bus(0, 12'h030, 0);
        chk(r, dir);
        bus(1, 12'h040, 32'hffff_ffff);
        bus(0, 12'h040, 0);
        chk(r, 0);
        @(posedge clk);
        nrst <= 1'b0;
        repeat (3) @(posedge clk);
        nrst <= 1'b1;
        bus(0, 12'h030, 0);
        chk(r, 0);
        bus(1, 12'h030, 3);
        bus(0, 12'h02c, 0);
        chk(r, lat);
        results();
    end
    initial begin
        #400000;
        errTotal++;
        results();
    end
endmodule : two_pin_port_direction_control_tb
